// ==== hw/crc_engine.sv ====
`default_nettype none
// Bit-serial CRC over a stream of 16-bit words, one bit per clock
module crc_engine
    import meter_evt_pkg::*;
#(
    parameter int WORDS = 4
)
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [WORDS*16-1:0]   data,
    output logic [15:0]                crc_q,
    output logic                       done_q
);
    localparam int BITS = WORDS * 16;
    logic [$clog2(BITS)-1:0] idx_q;
    logic [15:0]             acc_q;
    wire                     fb  = acc_q[15] ^ data[idx_q];
    wire  [15:0]             nxt = {acc_q[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0);
    wire                     last = (idx_q == ($clog2(BITS))'(BITS - 1));

    // ----------------------------------------------------------------
    // Free-running pass; result published at each pass end
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            idx_q  <= '0;
            acc_q  <= 16'hffff;
            crc_q  <= RST_WORD;
            done_q <= 1'b0;
        end
        else
        begin
            idx_q  <= last ? '0 : idx_q + 1'b1;
            acc_q  <= last ? 16'hffff : nxt;
            done_q <= last;
            if (last)
                crc_q <= nxt;
        end
    end
endmodule : crc_engine
`default_nettype wire

// ==== hw/meter_event_regs.sv ====
`default_nettype none
//
// Overview of operation
// - Enable A bits 15..13 gate over-current change interrupts, phases A, B, C.
// - Enable A bits 12..10 gate over-voltage change interrupts, phases A, B, C.
// - Enable A bit 9 voltage sequence error, bit 8 current sequence error.
// - Enable A bit 7 gates neutral over-current change interrupt.
// - Enable A bits 6..4: reactive, active, apparent no-load changes.
// - Enable A bits 3..0 gate pulse outputs one to four direction changes.
// - Enable B bit 15 frequency high, bit 11 frequency low.
// - Enable B bits 14..12 gate sag change interrupts, phases A, B, C.
// - Enable B bits 10..8 gate phase-loss change interrupts, phases A, B, C.
// - Enable B bits 7..4 reactive sign, bits 3..0 active sign changes.
// - Enable A at 75H, read/write, resets to zero.
// - Read-only 78H holds data word of last serial access.
// - Error register bit 1 flags internal register CRC mismatch.
// - Error register bit 0 flags configuration CRC mismatch; rest reserved.
// - Error register read-only at 79H, resets to zero.
// - Reading 7AH returns live configuration CRC; resets to zero.
// - Writes to 7AH change golden CRC only when unlocked.
// - Change flags clear on writing one; zero leaves them; reset zero.
// - Golden write permitted only while unlock register holds AA55.
// - Unlock neither key: latch CRC as golden, then keep comparing.
//
module meter_event_regs
    import meter_evt_pkg::*;
#(
    parameter int CFG_WORDS = 4
)
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    cs_n_pin,
    input  wire logic                    sclk_pin,
    input  wire logic                    mosi_pin,
    output logic                         miso_o,
    output logic                         miso_oe,
    input  wire logic [15:0]             event_change_a,
    input  wire logic [15:0]             event_change_b,
    input  wire logic [CFG_WORDS*16-1:0] config_words,
    input  wire logic                    internal_crc_bad,
    output logic [15:0]                  config_access_unlock,
    output logic                         irq_o
);
    // ----------------------------------------------------------------
    // Serial port and CRC engine
    // ----------------------------------------------------------------
    reg_req_s    req;
    logic        req_valid;
    logic        rd_valid;
    logic [15:0] rdata;
    logic        miso_r;
    logic        miso_oe_r;
    logic [15:0] crc_live;
    logic        crc_done;

    serial_port u_port (
        .clk       (clk),
        .rst_n     (rst_n),
        .cs_n_pin  (cs_n_pin),
        .sclk_pin  (sclk_pin),
        .mosi_pin  (mosi_pin),
        .miso_o    (miso_r),
        .miso_oe   (miso_oe_r),
        .req       (req),
        .req_valid (req_valid),
        .rd_valid  (rd_valid),
        .rdata     (rdata)
    );

    crc_engine #(.WORDS(CFG_WORDS)) u_crc (
        .clk    (clk),
        .rst_n  (rst_n),
        .data   (config_words),
        .crc_q  (crc_live),
        .done_q (crc_done)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0] en_a_q;
    logic [15:0] en_b_q;
    logic [15:0] flags_a_q;
    logic [15:0] flags_b_q;
    logic [15:0] last_q;
    logic [15:0] golden_q;
    logic        golden_ok_q;
    logic [1:0]  crc_err_q;
    logic [15:0] digest_q;
    logic [15:0] unlock_q;

    // Write decode
    wire wr       = req_valid & req.wr;
    wire wr_en_a  = wr & (req.addr == ADDR_IRQ_EN_A);
    wire wr_en_b  = wr & (req.addr == ADDR_IRQ_EN_B);
    wire wr_fl_a  = wr & (req.addr == ADDR_FLAGS_A);
    wire wr_fl_b  = wr & (req.addr == ADDR_FLAGS_B);
    wire wr_unl   = wr & (req.addr == ADDR_UNLOCK);
    wire wr_gold  = wr & (req.addr == ADDR_CRC_VALUE);
    wire key_gold = (unlock_q == KEY_GOLDEN);
    wire key_cfg  = (unlock_q == KEY_CONFIG);
    wire checking = ~key_cfg; // Golden key keeps checking as well
    wire [15:0] clr_a = wr_fl_a ? req.wdata : 16'h0;
    wire [15:0] clr_b = wr_fl_b ? req.wdata : 16'h0;

    // Read mux; unmapped addresses read zero
    assign rdata = (req.addr == ADDR_IRQ_EN_A)  ? en_a_q :
                   (req.addr == ADDR_IRQ_EN_B)  ? en_b_q :
                   (req.addr == ADDR_FLAGS_A)   ? flags_a_q :
                   (req.addr == ADDR_FLAGS_B)   ? flags_b_q :
                   (req.addr == ADDR_LAST_WORD) ? last_q :
                   (req.addr == ADDR_CRC_ERR)   ? {14'h0, crc_err_q} :
                   (req.addr == ADDR_CRC_VALUE) ? digest_q :
                   (req.addr == ADDR_UNLOCK)    ? unlock_q : 16'h0;

    // Enables gate only; events still set their flags while disabled
    wire irq_d = |(flags_a_q & en_a_q) | |(flags_b_q & en_b_q);

    // ----------------------------------------------------------------
    // Enable, flag and unlock registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            en_a_q    <= RST_WORD;
            en_b_q    <= RST_WORD;
            flags_a_q <= RST_WORD;
            flags_b_q <= RST_WORD;
            unlock_q  <= RST_WORD;
            irq_o     <= 1'b0;
        end
        else
        begin
            if (wr_en_a)
                en_a_q <= req.wdata;
            if (wr_en_b)
                en_b_q <= req.wdata;
            // New event wins over a same-cycle clear
            flags_a_q <= (flags_a_q & ~clr_a) | event_change_a;
            flags_b_q <= (flags_b_q & ~clr_b) | event_change_b;
            if (wr_unl)
                unlock_q <= req.wdata;
            irq_o <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // Last access word and CRC check
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            last_q      <= RST_WORD;
            golden_q    <= RST_WORD;
            golden_ok_q <= 1'b0;
            crc_err_q   <= 2'b00;
            digest_q    <= RST_WORD;
        end
        else
        begin
            if (req_valid && req.wr)
                last_q <= req.wdata;
            else if (rd_valid)
                last_q <= rdata;
            if (crc_done)
                digest_q <= crc_live;
            crc_err_q[CRC_ERR_INT_BIT] <= internal_crc_bad;
            if (!checking)
            begin
                golden_ok_q <= 1'b0;
                crc_err_q[CRC_ERR_CFG_BIT] <= 1'b0;
            end
            else if (wr_gold && key_gold)
            begin
                golden_q    <= req.wdata;
                golden_ok_q <= 1'b1;
            end
            else if (crc_done && !golden_ok_q)
            begin
                golden_q    <= crc_live;
                golden_ok_q <= 1'b1;
            end
            else if (crc_done)
                crc_err_q[CRC_ERR_CFG_BIT] <= (crc_live != golden_q);
        end
    end

    assign miso_o  = miso_r;
    assign miso_oe = miso_oe_r;
    assign config_access_unlock = unlock_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    irq_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_o == $past(irq_d))
        else $error("irq does not follow enabled flags");
    flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(flags_a_q[0]) && !$past(clr_a[0])) |-> flags_a_q[0])
        else $error("flag dropped without write one");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(event_change_b[3]) |-> flags_b_q[3])
        else $error("event lost");
    gold_locked_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_gold && !key_gold && golden_ok_q && checking) |=> $stable(golden_q))
        else $error("golden changed while locked");
    gold_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_gold && key_gold) |=> golden_q == $past(req.wdata))
        else $error("golden write not taken");
    cfg_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        (crc_done && checking && golden_ok_q && !(wr_gold && key_gold) && crc_live != golden_q)
        |=> crc_err_q[CRC_ERR_CFG_BIT])
        else $error("crc mismatch not flagged");
    int_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        internal_crc_bad |=> crc_err_q[CRC_ERR_INT_BIT])
        else $error("internal crc error not flagged");
    last_word_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req.wr) |=> last_q == $past(req.wdata))
        else $error("last word not logged");
    en_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en_a |=> en_a_q == $past(req.wdata))
        else $error("enable register not written");
endmodule : meter_event_regs
`default_nettype wire

// ==== hw/serial_port.sv ====
`default_nettype none
// Four-wire serial slave: mode 0, MSB first, 32-bit frames
module serial_port
    import meter_evt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cs_n_pin,
    input  wire logic        sclk_pin,
    input  wire logic        mosi_pin,
    output logic             miso_o,
    output logic             miso_oe,
    output reg_req_s         req,
    output logic             req_valid,
    output logic             rd_valid,
    input  wire logic [15:0] rdata
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic       sclk_d1_q;
    always_ff @(posedge clk)
    begin
        s1_q <= {cs_n_pin, sclk_pin, mosi_pin};
        s2_q <= s1_q;
        sclk_d1_q <= s2_q[1];
        // Registered so the pin enable comes straight from a flop
        miso_oe <= ~s2_q[2];
    end
    wire cs_n   = s2_q[2];
    wire sclk   = s2_q[1];
    wire mosi   = s2_q[0];
    wire rise   = sclk & ~sclk_d1_q;
    wire fall   = ~sclk & sclk_d1_q;

    logic [5:0]  cnt_q;
    logic        fetch_q;
    logic [31:0] sh_q;
    logic [15:0] out_q;
    wire  [31:0] sh_d = {sh_q[30:0], mosi};
    // Read data is fetched once the 16 header bits are in
    wire         hdr_done = rise & (cnt_q == 6'd15);
    wire         frm_done = rise & (cnt_q == 6'd31);

    // ----------------------------------------------------------------
    // Shift engine; a frame aborted by cs_n high is simply dropped
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n || cs_n)
        begin
            cnt_q     <= 6'd0;
            fetch_q   <= 1'b0;
            sh_q      <= 32'h0;
            out_q     <= 16'h0;
            miso_o    <= 1'b0;
            req_valid <= 1'b0;
            rd_valid  <= 1'b0;
            req       <= '0;
        end
        else
        begin
            req_valid <= 1'b0;
            rd_valid  <= 1'b0;
            if (rise)
            begin
                sh_q  <= sh_d;
                cnt_q <= cnt_q + 6'd1;
            end
            if (hdr_done && sh_d[15])
            begin
                req.addr <= sh_d[6:0];
                req.wr   <= 1'b0;
            end
            // Data for the read arrives one cycle after the fetch
            fetch_q <= hdr_done & sh_d[15];
            // Loaded once only; a reload after the first shift would repeat bits
            if (fetch_q)
                out_q <= rdata;
            if (fall && cnt_q >= 6'd16)
            begin
                miso_o <= out_q[15];
                out_q  <= {out_q[14:0], 1'b0};
            end
            if (frm_done)
            begin
                req.wr    <= ~sh_q[30];
                req.addr  <= sh_q[21:15];
                req.wdata <= sh_d[15:0];
                req_valid <= 1'b1;
                rd_valid  <= sh_q[30];
            end
        end
    end
endmodule : serial_port
`default_nettype wire

// ==== shared/meter_evt_pkg.sv ====
`default_nettype none
package meter_evt_pkg;
    // ----------------------------------------------------------------
    // Register map (word addresses)
    // ----------------------------------------------------------------
    localparam logic [6:0]  ADDR_FLAGS_A    = 7'h73;
    localparam logic [6:0]  ADDR_FLAGS_B    = 7'h74;
    localparam logic [6:0]  ADDR_IRQ_EN_A   = 7'h75;
    localparam logic [6:0]  ADDR_IRQ_EN_B   = 7'h76;
    localparam logic [6:0]  ADDR_LAST_WORD  = 7'h78;
    localparam logic [6:0]  ADDR_CRC_ERR    = 7'h79;
    localparam logic [6:0]  ADDR_CRC_VALUE  = 7'h7a;
    localparam logic [6:0]  ADDR_UNLOCK     = 7'h7f;
    // ----------------------------------------------------------------
    // Reset values and unlock keys
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [15:0] KEY_CONFIG      = 16'h55aa;
    localparam logic [15:0] KEY_GOLDEN      = 16'haa55;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          CRC_ERR_CFG_BIT = 0;
    localparam int          CRC_ERR_INT_BIT = 1;
    localparam logic [15:0] CRC_POLY        = 16'h1021;
    // Serial frame: R/W bit, 8 unused bits, 7 address bits, 16 data bits
    localparam int          FRAME_BITS      = 32;

    // Register access request from the serial port
    typedef struct packed {
        logic        wr;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } reg_req_s;
endpackage : meter_evt_pkg
`default_nettype wire

// ==== tb/spi_host_model.sv ====
`default_nettype none
// --------------------------------------------------------------------
// Microcontroller side of the four-wire serial port
// --------------------------------------------------------------------
module spi_host_model
    import meter_evt_pkg::*;
#(
    parameter int HALF = 6
)
(
    input  wire logic clk,
    output logic      cs_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus: deselected, clock parked low
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // One 32-bit frame, mode 0, MSB first; clock stands still outside it
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata);
        logic [31:0] frame;
        frame = {rd, 8'h00, addr, wdata};
        rdata = '0;
        @(posedge clk);
        cs_n <= 1'b0;
        // Chip select passes a 2-FF synchroniser first
        repeat (4) @(posedge clk);
        for (int i = 31; i >= 0; i--)
        begin
            mosi <= frame[i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            // Undriven line reads as the inverse, so a dropped enable shows up
            if (i < 16)
                rdata[i] = miso_oe ? miso : ~miso;
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        cs_n <= 1'b1;
        // Released line shows the inverse, so nothing relies on a stale bit
        mosi <= ~frame[0];
        repeat (12) @(posedge clk);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ==== tb/tb_meter_event_regs.sv ====
`default_nettype none
module tb_meter_event_regs
    import meter_evt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst_n;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    logic [15:0] ev_a;
    logic [15:0] ev_b;
    logic [63:0] cfg;
    logic        int_bad;
    logic [15:0] unlock;
    logic        irq;
    logic [6:0]  en_addr;
    logic [6:0]  fl_addr;
    logic [15:0] bit_w;
    int          err_total;
    int          n_tests;

    // --------------------------------------------------------------------
    // Clock, design and host
    // --------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    meter_event_regs #(.CFG_WORDS(4)) u_dut (
        .clk                  (clk),
        .rst_n                (rst_n),
        .cs_n_pin             (cs_n),
        .sclk_pin             (sclk),
        .mosi_pin             (mosi),
        .miso_o               (miso),
        .miso_oe              (miso_oe),
        .event_change_a       (ev_a),
        .event_change_b       (ev_b),
        .config_words         (cfg),
        .internal_crc_bad     (int_bad),
        .config_access_unlock (unlock),
        .irq_o                (irq)
    );

    spi_host_model u_host (
        .clk     (clk),
        .cs_n    (cs_n),
        .sclk    (sclk),
        .mosi    (mosi),
        .miso    (miso),
        .miso_oe (miso_oe)
    );

    // --------------------------------------------------------------------
    // Checking and access helpers
    // --------------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] r;
        u_host.xfer(1'b0, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] r;
        u_host.xfer(1'b1, a, 16'h0000, r);
        chk16(r, exp);
    endtask : rd_chk

    // One-cycle event pulse, then time for flag and interrupt to land
    task automatic pulse(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk);
        ev_a <= a;
        ev_b <= b;
        @(posedge clk);
        ev_a <= '0;
        ev_b <= '0;
        repeat (3) @(posedge clk);
    endtask : pulse

    // Own model of the digest, bit 0 of the config words first
    function automatic logic [15:0] crc_of(input logic [63:0] w);
        logic [15:0] c;
        logic        fb;
        c = 16'hffff;
        for (int i = 0; i < 64; i++)
        begin
            fb = c[15] ^ w[i];
            c  = {c[14:0], 1'b0};
            if (fb)
                c = c ^ CRC_POLY;
        end
        return c;
    endfunction : crc_of

    // Bounded run: the sequence needs roughly 60k cycles
    initial
    begin
        repeat (90000) @(posedge clk);
        err_total++;
        test_done;
    end

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial
    begin
        rst_n     = 1'b0;
        ev_a      = '0;
        ev_b      = '0;
        cfg       = 64'h0123_4567_89ab_cdef;
        int_bad   = 1'b0;
        err_total = 0;
        n_tests   = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk16(unlock, RST_WORD);
        chk1(irq, 1'b0);
        rd_chk(ADDR_IRQ_EN_A, RST_WORD);
        rd_chk(ADDR_CRC_ERR, RST_WORD);
        rd_chk(ADDR_CRC_VALUE, crc_of(cfg));
        rd_chk(7'h70, 16'h0000);
        wr(ADDR_IRQ_EN_B, 16'hbeef);
        rd_chk(ADDR_LAST_WORD, 16'hbeef);
        wr(ADDR_CRC_ERR, 16'hffff);
        rd_chk(ADDR_CRC_ERR, RST_WORD);
        rd_chk(ADDR_LAST_WORD, RST_WORD);
        wr(ADDR_IRQ_EN_B, 16'h0000);
        // Each enable alone: wrong flag stays quiet, own flag fires
        for (int h = 0; h < 2; h++)
        begin
            en_addr = (h == 0) ? ADDR_IRQ_EN_A : ADDR_IRQ_EN_B;
            fl_addr = (h == 0) ? ADDR_FLAGS_A : ADDR_FLAGS_B;
            for (int b = 0; b < 16; b++)
            begin
                bit_w = 16'h0001 << b;
                wr(en_addr, bit_w);
                rd_chk(en_addr, bit_w);
                if (h == 0)
                    pulse({bit_w[14:0], bit_w[15]}, 16'h0000);
                else
                    pulse(16'h0000, {bit_w[14:0], bit_w[15]});
                chk1(irq, 1'b0);
                if (h == 0)
                    pulse(bit_w, 16'h0000);
                else
                    pulse(16'h0000, bit_w);
                chk1(irq, 1'b1);
                wr(fl_addr, 16'h0000);
                chk1(irq, 1'b1);
                wr(fl_addr, 16'hffff);
                chk1(irq, 1'b0);
            end
            wr(en_addr, 16'h0000);
        end
        // Error register and digest behaviour
        int_bad <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(ADDR_CRC_ERR, 16'h0002);
        int_bad <= 1'b0;
        cfg     <= cfg ^ 64'h1;
        repeat (200) @(posedge clk);
        rd_chk(ADDR_CRC_ERR, 16'h0001);
        rd_chk(ADDR_CRC_VALUE, crc_of(cfg));
        wr(ADDR_UNLOCK, KEY_CONFIG);
        chk16(unlock, KEY_CONFIG);
        rd_chk(ADDR_CRC_ERR, RST_WORD);
        wr(ADDR_UNLOCK, 16'h0000);
        repeat (200) @(posedge clk);
        rd_chk(ADDR_CRC_ERR, RST_WORD);
        wr(ADDR_CRC_VALUE, 16'h1234);
        repeat (200) @(posedge clk);
        rd_chk(ADDR_CRC_ERR, RST_WORD);
        wr(ADDR_UNLOCK, KEY_GOLDEN);
        wr(ADDR_CRC_VALUE, 16'h1234);
        repeat (200) @(posedge clk);
        rd_chk(ADDR_CRC_ERR, 16'h0001);
        test_done;
    end
endmodule : tb_meter_event_regs
`default_nettype wire
